//--- include/dsw_pkg.sv
/*
 * Shared constants and carriers of the dual switch control block: frame layout,
 * per-channel configuration, fault flags, response word and timing counts.
 * Assumes a 100 MHz reference clock; all counts below are derived from it.
 */
package dsw_pkg;

    // ************************************************************
    // frame and clock
    // ************************************************************
    localparam int FRAME_BITS = 16;
    localparam int CLK_MHZ = 100;
    localparam int EDGE_CNT_W = 8;
    localparam int ADDR_MSB = 15;
    localparam int ADDR_LSB = 13;
    localparam int DATA_MSB = 12;
    localparam logic [2:0] ADDR_NOP = 3'h0;
    localparam logic [2:0] ADDR_CH0 = 3'h1;
    localparam logic [2:0] ADDR_CH1 = 3'h2;
    localparam logic [2:0] ADDR_GLB = 3'h3;
    localparam int GLB_SENSE_LSB = 0;
    localparam int GLB_CLEAR_BIT = 2;

    // ************************************************************
    // modes and carriers
    // ************************************************************
    typedef enum logic [1:0] {
        DSW_MODE_DIRECT,
        DSW_MODE_INT_PWM,
        DSW_MODE_EXT_PWM,
        DSW_MODE_OFF
    } dsw_mode_t;

    typedef enum logic [1:0] {
        DSW_SENSE_CH0,
        DSW_SENSE_CH1,
        DSW_SENSE_TEMP,
        DSW_SENSE_NONE
    } dsw_sense_t;

    typedef struct packed {
        logic [3:0] duty;
        logic [1:0] ratio;
        logic [1:0] slew;
        logic retry_en;
        logic prof_motor;
        logic prof_spi_en;
        dsw_mode_t mode;
    } dsw_chan_cfg_t;

    typedef struct packed {
        logic ol_on;
        logic ol_off;
        logic ot;
        logic sc;
        logic oc;
    } dsw_fault_in_t;

    typedef struct packed {
        logic ol;
        logic ot;
        logic sc;
        logic oc;
    } dsw_chan_stat_t;

    typedef struct packed {
        logic failsafe;
        logic [1:0] held_off;
        logic [1:0] sw_on;
        dsw_sense_t sense_sel;
        logic spare;
        dsw_chan_stat_t stat1;
        dsw_chan_stat_t stat0;
    } dsw_resp_t;

    localparam dsw_chan_cfg_t CFG_RST = 13'h0000;
    localparam logic [2:0] OC_LVL_MAX = 3'h7;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int WDOG_TIME_US = 32000;
    localparam int RETRY_TIME_US = 10000;
    localparam int BULB_STEP_US = 1000;
    localparam int MOTOR_STEP_US = 8000;
    localparam int PWM_TICK_NS = 10000;
    localparam int SETTLE_TIME_NS = 20000;
    localparam int WDOG_CYC = WDOG_TIME_US * CLK_MHZ;
    localparam int RETRY_CYC = RETRY_TIME_US * CLK_MHZ;
    localparam int BULB_STEP_CYC = BULB_STEP_US * CLK_MHZ;
    localparam int MOTOR_STEP_CYC = MOTOR_STEP_US * CLK_MHZ;
    localparam int PWM_TICK_CYC = (PWM_TICK_NS * CLK_MHZ + 999) / 1000;
    localparam int SETTLE_CYC = (SETTLE_TIME_NS * CLK_MHZ + 999) / 1000;

endpackage

//--- hdl/dsw_spi_link.sv
/*
 * Serial-clock side of the control port: counts serial clock edges while the
 * chip select is low, shifts the serial input in and drives the serial output.
 * Assumes the serial clock stands still while chip select is high, so that the
 * edge count and the received word are stable when the reference side reads them.
 */
`timescale 1ns/1ps
`default_nettype none

module dsw_spi_link
    import dsw_pkg::*;
(
    // link clock and reset
    input wire logic sclk,
    input wire logic rst,
    // serial pins
    input wire logic chip_select_n,
    input wire logic si,
    output logic so,
    output logic so_oe,
    // reference side
    input wire logic [EDGE_CNT_W-1:0] base,
    input wire logic [FRAME_BITS-1:0] resp,
    output logic [EDGE_CNT_W-1:0] edge_cnt,
    output logic [FRAME_BITS-1:0] rx_word
);

    typedef struct packed {
        logic [EDGE_CNT_W-1:0] cnt;
        logic [FRAME_BITS-1:0] shreg;
    } dsw_link_state_t;

    dsw_link_state_t st_q;
    dsw_link_state_t st_d;
    logic [EDGE_CNT_W-1:0] pos;

    // free-running edge count; the reference side subtracts the count seen at
    // the previous frame end, so no reset is needed between frames
    always_comb begin
        st_d = st_q;
        if (!chip_select_n) begin
            st_d.cnt = st_q.cnt + 8'h01;
            st_d.shreg = {st_q.shreg[FRAME_BITS-2:0], si};
        end
    end

    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // first sixteen bits carry our answer, later bits pass the chain along
    always_comb begin
        pos = st_q.cnt - base;
        if (pos < 8'h10) begin
            so = resp[4'hF - pos[3:0]];
        end else begin
            so = st_q.shreg[FRAME_BITS-1];
        end
        so_oe = !chip_select_n;
    end

    assign edge_cnt = st_q.cnt;
    assign rx_word = st_q.shreg;

endmodule

`default_nettype wire

//--- hdl/dsw_ctrl.sv
/*
 * Control and supervision logic of a dual high-side switch: serial frame
 * decode, fail-safe watchdog, per-channel switching source, overcurrent
 * profile, latched protection with retry, open-load flags and sense selection.
 * Assumes analog comparators deliver fault_in on ref_clk; pins are synchronised.
 */
// Functional notes
// - sixteen-bit serial frames, up to 8 MHz
// - lost communication enters fail-safe, still switching
// - fail-safe pin pulled low in fail-safe
// - fault pin pulled low on any fault
// - channel driven by internal, external clock, direct
// - direct input sets switch; undriven reads low
// - profile pin picks bulb or motor
// - external clock gives external PWM time base
// - reset pin clears configuration and faults
// - reset sleeps unless a direct input active
// - serial picks current or temperature sense
// - per-channel programmable sense ratio
// - profile also selectable by serial command
// - protection switches off, optional automatic retry
// - per-channel programmable slew rate
// - overcurrent threshold decays after switch-on
// - overcurrent latched, bulb and motor handled differently
// - open load checked off and on
// - serial output answers or passes chain
// - sync pin low while sense settled
`timescale 1ns/1ps
`default_nettype none

module dsw_ctrl
    import dsw_pkg::*;
#(
    parameter int unsigned WDOG_CYCLES = WDOG_CYC,
    parameter int unsigned RETRY_CYCLES = RETRY_CYC,
    parameter int unsigned BULB_STEP_CYCLES = BULB_STEP_CYC,
    parameter int unsigned MOTOR_STEP_CYCLES = MOTOR_STEP_CYC
) (
    // reference clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    // serial link
    input wire logic sclk,
    input wire logic chip_select_n,
    input wire logic si,
    output logic so,
    output logic so_oe,
    // direct pins
    input wire logic [1:0] direct_in,
    input wire logic [1:0] profile_select_inputs,
    input wire logic pwm_clk,
    input wire logic reset_n_input,
    // analog protection comparators
    input wire dsw_fault_in_t [1:0] fault_in,
    // switch drive
    output logic switch_output_zero,
    output logic switch_output_one,
    output logic [1:0][1:0] slew_sel,
    output logic [1:0][2:0] oc_level,
    output logic [1:0] oc_motor,
    // sense path
    output dsw_sense_t sense_output_sel,
    output logic [1:0] sense_ratio,
    output logic sense_sync_n_o,
    output logic sense_sync_n_oe,
    // open-drain indicators
    output logic failsafe_indicator_n_o,
    output logic failsafe_indicator_n_oe,
    output logic fault_status_n_o,
    output logic fault_status_n_oe,
    // power state
    output logic sleep
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [1:0] cs_s;
        logic [1:0] pc_s;
        logic [1:0] rb_s;
        logic [1:0][1:0] in_s;
        logic [1:0][1:0] pf_s;
        logic cs_prev;
        logic pc_prev;
        logic [EDGE_CNT_W-1:0] base;
        dsw_resp_t resp;
        dsw_chan_cfg_t [1:0] cfg;
        dsw_sense_t sense_sel;
        logic [1:0] ratio;
        dsw_chan_stat_t [1:0] stat;
        logic [1:0] held_off;
        logic [1:0][31:0] retry_cnt;
        logic [1:0][31:0] prof_cnt;
        logic [1:0][2:0] prof_lvl;
        logic [1:0] motor;
        logic [1:0] sw_on;
        logic [31:0] wd_cnt;
        logic failsafe;
        logic [15:0] pre_cnt;
        logic [3:0] int_phase;
        logic [3:0] ext_phase;
        logic [15:0] settle_cnt;
        logic settled;
        logic fault_any;
        logic sleep;
    } dsw_ctrl_state_t;

    dsw_ctrl_state_t st_q;
    dsw_ctrl_state_t st_d;

    logic [EDGE_CNT_W-1:0] edge_cnt;
    logic [FRAME_BITS-1:0] rx_word;

    function automatic logic pwm_high(input logic [3:0] duty, input logic [3:0] phase);
        pwm_high = phase < duty;
    endfunction

    function automatic logic cnt_done(input logic [31:0] cnt, input int unsigned lim);
        cnt_done = cnt >= (32'(lim) - 32'h1);
    endfunction

    // ************************************************************
    // serial clock domain
    // ************************************************************
    dsw_spi_link u_link (
        .sclk(sclk),
        .rst(rst),
        .chip_select_n(chip_select_n),
        .si(si),
        .so(so),
        .so_oe(so_oe),
        .base(st_q.base),
        .resp(st_q.resp),
        .edge_cnt(edge_cnt),
        .rx_word(rx_word)
    );

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        logic frame_end;
        logic frame_ok;
        logic [2:0] addr;
        logic clear;
        logic pin_reset;
        logic int_tick;
        logic ext_tick;
        logic req;
        logic trip;
        logic may_retry;
        logic [1:0] sw_next;
        dsw_chan_stat_t hit;
        int unsigned step;
        frame_end = 1'b0;
        frame_ok = 1'b0;
        addr = 3'h0;
        clear = 1'b0;
        pin_reset = 1'b0;
        int_tick = 1'b0;
        ext_tick = 1'b0;
        req = 1'b0;
        trip = 1'b0;
        may_retry = 1'b0;
        sw_next = 2'h0;
        hit = '0;
        step = 0;
        st_d = st_q;

        // two-stage synchronisers for every pin from outside ref_clk
        // select and reset pin kept active high: the zero reset state reads as idle
        st_d.cs_s = {st_q.cs_s[0], !chip_select_n};
        st_d.pc_s = {st_q.pc_s[0], pwm_clk};
        st_d.rb_s = {st_q.rb_s[0], !reset_n_input};
        for (int ch = 0; ch < 2; ch++) begin
            st_d.in_s[ch] = {st_q.in_s[ch][0], direct_in[ch]};
            st_d.pf_s[ch] = {st_q.pf_s[ch][0], profile_select_inputs[ch]};
        end
        st_d.cs_prev = st_q.cs_s[1];
        st_d.pc_prev = st_q.pc_s[1];
        pin_reset = st_q.rb_s[1];

        // chip select rising: the link clock has stopped, count and word are stable
        frame_end = !st_q.cs_s[1] && st_q.cs_prev;
        if (frame_end) begin
            frame_ok = (edge_cnt - st_q.base) == 8'(FRAME_BITS);
            st_d.base = edge_cnt;
        end
        addr = rx_word[ADDR_MSB:ADDR_LSB];
        if (frame_ok) begin
            unique case (addr)
                ADDR_CH0: st_d.cfg[0] = dsw_chan_cfg_t'(rx_word[DATA_MSB:0]);
                ADDR_CH1: st_d.cfg[1] = dsw_chan_cfg_t'(rx_word[DATA_MSB:0]);
                ADDR_GLB: begin
                    st_d.sense_sel = dsw_sense_t'(rx_word[GLB_SENSE_LSB +: 2]);
                    clear = rx_word[GLB_CLEAR_BIT];
                end
                default: ;
            endcase
        end

        // communication watchdog; any good frame counts as contact
        if (frame_ok) begin
            st_d.wd_cnt = 32'h0;
            st_d.failsafe = 1'b0;
        end else if (!st_q.failsafe) begin
            if (cnt_done(st_q.wd_cnt, WDOG_CYCLES)) begin
                st_d.failsafe = 1'b1;
            end else begin
                st_d.wd_cnt = st_q.wd_cnt + 32'h1;
            end
        end

        // internal time base from ref_clk, external from the pwm clock pin
        if (st_q.pre_cnt >= 16'(PWM_TICK_CYC - 1)) begin
            st_d.pre_cnt = 16'h0;
            int_tick = 1'b1;
        end else begin
            st_d.pre_cnt = st_q.pre_cnt + 16'h1;
        end
        ext_tick = st_q.pc_s[1] && !st_q.pc_prev;
        if (int_tick) begin
            st_d.int_phase = st_q.int_phase + 4'h1;
        end
        if (ext_tick) begin
            st_d.ext_phase = st_q.ext_phase + 4'h1;
        end

        for (int ch = 0; ch < 2; ch++) begin
            // fail-safe falls back to the direct inputs and pin profiles
            if (st_q.failsafe || st_q.cfg[ch].mode == DSW_MODE_DIRECT) begin
                req = st_q.in_s[ch][1];
            end else if (st_q.cfg[ch].mode == DSW_MODE_INT_PWM) begin
                req = pwm_high(st_q.cfg[ch].duty, st_q.int_phase);
            end else if (st_q.cfg[ch].mode == DSW_MODE_EXT_PWM) begin
                req = pwm_high(st_q.cfg[ch].duty, st_q.ext_phase);
            end else begin
                req = 1'b0;
            end
            if (st_q.cfg[ch].prof_spi_en && !st_q.failsafe) begin
                st_d.motor[ch] = st_q.cfg[ch].prof_motor;
            end else begin
                st_d.motor[ch] = st_q.pf_s[ch][1];
            end

            // overcurrent and short circuit only trip a channel that is on; overtemperature trips it on or off
            hit = '0;
            hit.oc = st_q.sw_on[ch] && fault_in[ch].oc;
            hit.sc = st_q.sw_on[ch] && fault_in[ch].sc;
            hit.ot = fault_in[ch].ot;
            hit.ol = st_q.sw_on[ch] ? fault_in[ch].ol_on : fault_in[ch].ol_off;
            trip = hit.oc || hit.sc || hit.ot;
            // a new event wins over a clear in the same cycle
            st_d.stat[ch] = (clear ? dsw_chan_stat_t'(4'h0) : st_q.stat[ch]) | hit;

            // a motor overcurrent stays off until cleared; others may retry
            may_retry = st_q.cfg[ch].retry_en && !(st_q.stat[ch].oc && st_q.motor[ch]);
            if (trip) begin
                st_d.held_off[ch] = 1'b1;
                st_d.retry_cnt[ch] = 32'h0;
            end else if (clear) begin
                st_d.held_off[ch] = 1'b0;
            end else if (st_q.held_off[ch] && may_retry) begin
                if (cnt_done(st_q.retry_cnt[ch], RETRY_CYCLES)) begin
                    st_d.held_off[ch] = 1'b0;
                    st_d.retry_cnt[ch] = 32'h0;
                end else begin
                    st_d.retry_cnt[ch] = st_q.retry_cnt[ch] + 32'h1;
                end
            end
            sw_next[ch] = req && !st_d.held_off[ch];
            st_d.sw_on[ch] = sw_next[ch];

            // threshold starts high at switch-on and steps down to the steady level
            step = st_q.motor[ch] ? MOTOR_STEP_CYCLES : BULB_STEP_CYCLES;
            if (sw_next[ch] && !st_q.sw_on[ch]) begin
                st_d.prof_lvl[ch] = OC_LVL_MAX;
                st_d.prof_cnt[ch] = 32'h0;
            end else if (st_q.sw_on[ch] && st_q.prof_lvl[ch] != 3'h0) begin
                if (cnt_done(st_q.prof_cnt[ch], step)) begin
                    st_d.prof_lvl[ch] = st_q.prof_lvl[ch] - 3'h1;
                    st_d.prof_cnt[ch] = 32'h0;
                end else begin
                    st_d.prof_cnt[ch] = st_q.prof_cnt[ch] + 32'h1;
                end
            end
        end

        // reset pin clears configuration and faults, not the link bookkeeping
        if (pin_reset) begin
            st_d.cfg = {CFG_RST, CFG_RST};
            st_d.sense_sel = DSW_SENSE_CH0;
            st_d.stat = '0;
            st_d.held_off = 2'h0;
            st_d.failsafe = 1'b0;
            st_d.wd_cnt = 32'h0;
        end
        st_d.sleep = pin_reset && !(st_q.in_s[0][1] || st_q.in_s[1][1]);

        // sense is trusted only after a quiet settling time
        if (st_d.sense_sel != st_q.sense_sel || st_d.sw_on != st_q.sw_on) begin
            st_d.settle_cnt = 16'h0;
            st_d.settled = 1'b0;
        end else if (st_q.settle_cnt >= 16'(SETTLE_CYC - 1)) begin
            st_d.settled = 1'b1;
        end else begin
            st_d.settle_cnt = st_q.settle_cnt + 16'h1;
        end

        // the ratio follows the channel being sensed
        st_d.ratio = st_d.cfg[st_d.sense_sel == DSW_SENSE_CH1].ratio;
        st_d.fault_any = |st_d.stat;

        // answer loaded for the next frame while chip select is high
        st_d.resp.failsafe = st_d.failsafe;
        st_d.resp.held_off = st_d.held_off;
        st_d.resp.sw_on = st_d.sw_on;
        st_d.resp.sense_sel = st_d.sense_sel;
        st_d.resp.spare = 1'b0;
        st_d.resp.stat1 = st_d.stat[1];
        st_d.resp.stat0 = st_d.stat[0];
        if (st_q.cs_s[1]) begin
            st_d.resp = st_q.resp; // hold it stable for the frame in flight
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_q <= '0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign switch_output_zero = st_q.sw_on[0];
    assign switch_output_one = st_q.sw_on[1];
    assign oc_level = st_q.prof_lvl;
    assign oc_motor = st_q.motor;
    assign slew_sel[0] = st_q.cfg[0].slew;
    assign slew_sel[1] = st_q.cfg[1].slew;
    assign sense_output_sel = st_q.sense_sel;
    assign sense_ratio = st_q.ratio;
    assign sense_sync_n_o = 1'b0;
    assign sense_sync_n_oe = st_q.settled;
    assign failsafe_indicator_n_o = 1'b0;
    assign failsafe_indicator_n_oe = st_q.failsafe;
    assign fault_status_n_o = 1'b0;
    assign fault_status_n_oe = st_q.fault_any;
    assign sleep = st_q.sleep;

endmodule

`default_nettype wire

//--- tb/dsw_ctrl_monitor.sv
/*
 * Port checker of the dual switch control block, bound onto every dsw_ctrl.
 * Assumes the ref_clk domain only; serial side is judged through so_oe.
 */
`timescale 1ns/1ps
`default_nettype none

module dsw_ctrl_monitor
    import dsw_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // observed pins
    input wire logic chip_select_n,
    input wire logic so_oe,
    input wire logic [1:0] direct_in,
    input wire logic reset_n_input,
    input wire dsw_fault_in_t [1:0] fault_in,
    input wire logic switch_output_zero,
    input wire logic [1:0][2:0] oc_level,
    input wire logic failsafe_indicator_n_o,
    input wire logic failsafe_indicator_n_oe,
    input wire logic fault_status_n_o,
    input wire logic fault_status_n_oe,
    input wire logic sleep
);
    // ************************************************************
    // properties
    // ************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_fsi_level; failsafe_indicator_n_oe |-> !failsafe_indicator_n_o; endproperty
    a_fsi_level: assert property (p_fsi_level) else $error("failsafe pin driven high");
    property p_fault_level; fault_status_n_oe |-> !fault_status_n_o; endproperty
    a_fault_level: assert property (p_fault_level) else $error("fault pin driven high");
    property p_reset_release; $past(rst) |-> !failsafe_indicator_n_oe && !fault_status_n_oe;
    endproperty
    a_reset_release: assert property (p_reset_release) else $error("pin held after reset");
    property p_so_enable; so_oe == !chip_select_n; endproperty
    a_so_enable: assert property (p_so_enable) else $error("serial out enable wrong");
    property p_awake; reset_n_input [*6] |-> !sleep; endproperty
    a_awake: assert property (p_awake) else $error("asleep with reset pin high");
    property p_serve_direct; (direct_in != 2'h0) [*6] |-> !sleep; endproperty
    a_serve_direct: assert property (p_serve_direct) else $error("asleep with input");
    property p_sleep_cause; (!reset_n_input && direct_in == 2'h0) [*8] |-> sleep; endproperty
    a_sleep_cause: assert property (p_sleep_cause) else $error("no sleep in reset");
    property p_ot_off; switch_output_zero && fault_in[0].ot |-> ##[1:2] !switch_output_zero;
    endproperty
    a_ot_off: assert property (p_ot_off) else $error("channel kept on in fault");
    property p_ot_flag; fault_in[0].ot && reset_n_input |-> ##[1:3] fault_status_n_oe; endproperty
    a_ot_flag: assert property (p_ot_flag) else $error("fault pin not pulled");
    property p_oc_start; $rose(switch_output_zero) |-> ##[0:1] oc_level[0] == OC_LVL_MAX;
    endproperty
    a_oc_start: assert property (p_oc_start) else $error("threshold not at top");
endmodule

bind dsw_ctrl dsw_ctrl_monitor u_mon (.ref_clk(ref_clk), .rst(rst),
    .chip_select_n(chip_select_n), .so_oe(so_oe), .direct_in(direct_in),
    .reset_n_input(reset_n_input), .fault_in(fault_in), .switch_output_zero(switch_output_zero),
    .oc_level(oc_level), .failsafe_indicator_n_o(failsafe_indicator_n_o),
    .failsafe_indicator_n_oe(failsafe_indicator_n_oe), .fault_status_n_o(fault_status_n_o),
    .fault_status_n_oe(fault_status_n_oe), .sleep(sleep));

`default_nettype wire

//--- tb/dsw_spi_master_model.sv
/*
 * Controller model on the serial side: sends frames of any edge count, MSB first.
 * Assumes the device samples si on rising sclk; sclk stands low outside frames.
 */
`timescale 1ns/1ps
`default_nettype none

module dsw_spi_master_model (
    // serial pins
    output logic sclk,
    output logic chip_select_n,
    output logic si,
    input wire logic so
);
    logic [15:0] rx; // answer as seen on so, first bit before the first rise
    initial begin
        sclk = 1'b0;
        chip_select_n = 1'b1;
        si = 1'b0;
    end

    // n rising edges, word bits first then zeros; 64 ns period
    task automatic frame(input logic [15:0] w, input int n);
        logic [15:0] sh;
        sh = w;
        #3 chip_select_n = 1'b0; // low for the whole frame
        for (int i = 0; i < n; i++) begin
            si = sh[15];
            sh = {sh[14:0], 1'b0};
            #32;
            rx = {rx[14:0], so};
            sclk = 1'b1;
            #32 sclk = 1'b0;
        end
        #32 chip_select_n = 1'b1;
        si = 1'b0; // released line settles to its pull-down level
        #200;
    endtask
endmodule

`default_nettype wire

//--- tb/dsw_ctrl_tb_top.sv
/*
 * Self-checking bench of dsw_ctrl: direct, serial, pwm, fault, reset pin, fail-safe.
 * Assumes the short sim counts set below; ce is held high throughout.
 */
`timescale 1ns/1ps
`default_nettype none

module dsw_ctrl_tb_top;
    import dsw_pkg::*;
    logic ref_clk, rst, ce, sclk, chip_select_n, si, so, so_oe, pwm_clk, reset_n_input, sleep;
    logic switch_output_zero, switch_output_one, sense_sync_n_o, sense_sync_n_oe;
    logic failsafe_indicator_n_o, failsafe_indicator_n_oe, fault_status_n_o, fault_status_n_oe;
    logic [1:0] direct_in, profile_select_inputs, oc_motor, sense_ratio;
    logic [1:0][1:0] slew_sel;
    logic [1:0][2:0] oc_level;
    dsw_sense_t sense_output_sel;
    dsw_fault_in_t [1:0] fault_in;
    int n_mismatch = 0;
    int comparisons = 0;

    dsw_ctrl #(.WDOG_CYCLES(3000), .RETRY_CYCLES(50), .BULB_STEP_CYCLES(10),
        .MOTOR_STEP_CYCLES(20)) uut (.ref_clk, .rst, .ce, .sclk, .chip_select_n, .si, .so,
        .so_oe, .direct_in, .profile_select_inputs, .pwm_clk, .reset_n_input, .fault_in,
        .switch_output_zero, .switch_output_one, .slew_sel, .oc_level, .oc_motor,
        .sense_output_sel, .sense_ratio, .sense_sync_n_o, .sense_sync_n_oe,
        .failsafe_indicator_n_o, .failsafe_indicator_n_oe, .fault_status_n_o,
        .fault_status_n_oe, .sleep);
    dsw_spi_master_model spi (.sclk, .chip_select_n, .si, .so);

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // the serial frame ends off the ref_clk grid; re-align before touching pins
    task automatic send(input logic [2:0] a, input logic [12:0] d, input int n = 16);
        spi.frame({a, d}, n);
        cyc(8);
    endtask

    function automatic logic [1:0] exp_ratio(dsw_sense_t s, dsw_chan_cfg_t c0, dsw_chan_cfg_t c1);
        return (s == DSW_SENSE_CH1) ? c1.ratio : c0.ratio;
    endfunction

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ************************************************************
    // scenarios
    // ************************************************************
    initial begin
        logic [1:0] d;
        dsw_chan_cfg_t c0, c1;
        int cnt;
        rst = 1'b1;
        ce = 1'b1;
        pwm_clk = 1'b0;
        reset_n_input = 1'b1;
        direct_in = 2'h0;
        profile_select_inputs = 2'h0;
        fault_in = '0;
        void'($urandom(32'h189F1677));
        cyc(8);
        rst = 1'b0;
        cyc(4);
        chk(failsafe_indicator_n_oe, 1'b0, "failsafe after reset");
        chk(fault_status_n_oe, 1'b0, "fault after reset");
        repeat (4) begin
            d = 2'($urandom);
            direct_in = d;
            cyc(6);
            chk({switch_output_one, switch_output_zero}, d, "direct");
        end
        direct_in = 2'h3;
        c0 = dsw_chan_cfg_t'($urandom);
        c0.mode = DSW_MODE_OFF;
        c0.prof_spi_en = 1'b1;
        c1 = dsw_chan_cfg_t'($urandom);
        c1.mode = DSW_MODE_DIRECT;
        c1.prof_spi_en = 1'b0;
        send(ADDR_CH0, c0);
        send(ADDR_CH1, c1);
        chk({switch_output_one, switch_output_zero}, 2'h2, "mode off");
        chk(slew_sel, {c1.slew, c0.slew}, "slew");
        chk(oc_motor[0], c0.prof_motor, "serial profile");
        profile_select_inputs = 2'($urandom);
        cyc(6);
        chk(oc_motor[1], profile_select_inputs[1], "pin profile");
        for (int s = 3; s >= 0; s--) begin
            send(ADDR_GLB, 13'(s));
            chk(sense_output_sel, s, "sense select");
            chk(sense_ratio, exp_ratio(dsw_sense_t'(s), c0, c1), "ratio");
        end
        // 15 and 17 edges must both leave the slew untouched
        for (int n = 15; n <= 17; n += 2) begin
            send(ADDR_CH0, c0 ^ 13'h0060, n);
            chk(slew_sel[0], c0.slew, "short or long frame");
        end
        c0.mode = DSW_MODE_EXT_PWM;
        c0.duty = 4'($urandom);
        send(ADDR_CH0, c0);
        cnt = 0;
        repeat (16) begin
            pwm_clk = 1'b1;
            cyc(6);
            cnt += switch_output_zero;
            pwm_clk = 1'b0;
            cyc(6);
        end
        chk(cnt, c0.duty, "ext pwm on count");
        c0.mode = DSW_MODE_DIRECT;
        c0.retry_en = 1'b1;
        send(ADDR_CH0, c0);
        fault_in[0].ot = 1'b1;
        cyc(1);
        fault_in[0].ot = 1'b0;
        cyc(3);
        chk({fault_status_n_oe, switch_output_zero}, 2'h2, "fault off");
        cyc(70);
        chk(switch_output_zero, 1'b1, "retry on");
        send(ADDR_GLB, 13'h0004);
        chk(fault_status_n_oe, 1'b0, "fault cleared");
        direct_in = 2'h0;
        reset_n_input = 1'b0;
        cyc(10);
        chk({sleep, slew_sel[0]}, 3'h4, "reset pin");
        direct_in = 2'h1;
        cyc(6);
        chk({sleep, switch_output_zero}, 2'h1, "awake for input");
        reset_n_input = 1'b1;
        c0.mode = DSW_MODE_OFF;
        send(ADDR_CH0, c0);
        // silence on the link until the watchdog runs out, bounded
        for (int i = 0; i < 4000 && failsafe_indicator_n_oe !== 1'b1; i++) cyc(1);
        chk({sense_sync_n_oe, failsafe_indicator_n_oe}, 2'h3, "failsafe entry");
        cyc(6);
        chk({sense_sync_n_oe, switch_output_zero}, 2'h1, "failsafe direct");
        fault_in[1].ol_off = 1'b1; // ch1 is off, so the off-state check sees it
        send(ADDR_NOP, 13'h0000);
        chk(failsafe_indicator_n_oe, 1'b0, "failsafe exit");
        chk(spi.rx, 16'h8880, "answer word");
        summarize();
    end
endmodule

`default_nettype wire
